/* shared/ptc_pkg.sv */
// Constants, register map and carrier types for the timer output/interrupt block
package ptc_pkg;
    localparam int NCH   = 8;
    localparam int NPAIR = 4;

    // Register addresses
    localparam logic [15:0] ADDR_IRQ_EN_LO   = 16'hff25;
    localparam logic [15:0] ADDR_IRQ_FLAG_LO = 16'hff29;
    localparam logic [15:0] ADDR_IRQ_EN_HI   = 16'hff2c;
    localparam logic [15:0] ADDR_IRQ_FLAG_HI = 16'hff2e;
    localparam logic [15:0] ADDR_CTRL_BASE   = 16'hff40;
    localparam logic [15:0] ADDR_PRIO        = 16'hff48;
    localparam logic [15:0] ADDR_PIN         = 16'hff49;
    localparam logic [15:0] ADDR_RELOAD_BASE = 16'hff50;
    localparam logic [15:0] ADDR_CMP_BASE    = 16'hff58;
    localparam logic [15:0] ADDR_CNT_BASE    = 16'hff60;

    // Channel control register fields
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_OUT_BIT   = 1;
    localparam int CTRL_INV_BIT   = 2;
    localparam int CTRL_WIDTH_BIT = 7;

    // Pin register fields
    localparam int PIN_DIR_A_BIT  = 0;
    localparam int PIN_DIR_B_BIT  = 1;
    localparam int PIN_DIR_C_BIT  = 2;
    localparam int PIN_DATA_A_BIT = 4;
    localparam int PIN_DATA_B_BIT = 5;
    localparam int PIN_DATA_C_BIT = 6;

    // Reset values
    localparam logic [7:0] RESET_REG    = 8'h00;
    localparam logic [7:0] RESET_RELOAD = 8'hff;
    localparam logic [7:0] RESET_CMP    = 8'h00;
    localparam logic [7:0] RESET_CNT    = 8'hff;

    typedef enum logic [1:0] {
        PRIO_NONE  = 2'b00,
        PRIO_ONE   = 2'b01,
        PRIO_TWO   = 2'b10,
        PRIO_THREE = 2'b11
    } ptc_prio_t;

    typedef enum logic {
        RUN_STOPPED  = 1'b0,
        RUN_COUNTING = 1'b1
    } ptc_run_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } ptc_bus_req_t;

    typedef struct packed {
        logic level;
        logic oe_n;
    } ptc_pin_t;
endpackage : ptc_pkg

/* logic/ptc_timer_ctrl.sv */
// Eight-channel down-counter timer with pin routing and interrupt flags
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module ptc_timer_ctrl (
    input  logic                    clk_in,
    input  logic                    rstn_in,
    input  logic                    ce_in,
    input  ptc_pkg::ptc_bus_req_t   bus_in,
    output logic [7:0]              rdata_out,
    input  logic [7:0]              tclk_in,
    input  logic                    sleep_in,
    input  logic [1:0]              cpu_mask_level_in,
    output ptc_pkg::ptc_pin_t       pin_a_out,
    output ptc_pkg::ptc_pin_t       pin_b_out,
    output ptc_pkg::ptc_pin_t       pin_c_out,
    output logic [3:0]              irq_req_out
);
    import ptc_pkg::*;

    // Per-channel state
    logic [7:0] cnt     [NCH];
    logic [7:0] reload  [NCH];
    logic [7:0] cmp     [NCH];
    ptc_run_t   run_st  [NCH];
    logic       run_req [NCH];
    logic       out_en  [NCH];
    logic       inv_en  [NCH];
    logic       uf_en   [NCH];
    logic       cm_en   [NCH];
    logic       uf_flag [NCH];
    logic       cm_flag [NCH];
    logic       uf_ev   [NCH];
    logic       cm_ev   [NCH];
    logic       timer_out_clock    [NCH];
    logic       rl_pend [NCH];
    logic       tclk_q  [NCH];
    logic       fall    [NCH];
    logic       rise    [NCH];
    logic       cond    [NCH];
    logic       width   [NPAIR];
    ptc_prio_t  prio    [NPAIR];
    logic [7:0] pin_reg;
    logic [7:0] rd_en   [2];
    logic [7:0] rd_fl   [2];
    logic [7:0] next_rdata;

    // Run state step at a falling edge of the timer clock
    function automatic ptc_run_t next_run(input ptc_run_t st, input logic edge_f,
                                          input logic req);
        next_run = st;
        case (st)
            RUN_STOPPED:  if (edge_f && req) next_run = RUN_COUNTING;
            RUN_COUNTING: if (edge_f && !req) next_run = RUN_STOPPED;
            default:      next_run = RUN_STOPPED;
        endcase
    endfunction : next_run

    // Pin source choice, odd timer first
    function automatic ptc_pin_t pick_pin(input logic odd_en, input logic odd_lv,
                                          input logic even_en, input logic even_lv,
                                          input logic dir, input logic data);
        pick_pin.oe_n  = 1'b0;
        pick_pin.level = data;
        if (odd_en) begin
            pick_pin.level = odd_lv;
        end else if (even_en) begin
            pick_pin.level = even_lv;
        end else begin
            pick_pin.oe_n = !dir;
        end
    endfunction : pick_pin

    // Per-channel clock edge detect and register file
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        localparam int         P     = i / 2;
        localparam bit         IS_LO = (i % 2) == 0;
        localparam int         B     = 2 * (i % 4);
        localparam logic [15:0] FA   = (i < 4) ? ADDR_IRQ_FLAG_LO : ADDR_IRQ_FLAG_HI;
        localparam logic [15:0] EA   = (i < 4) ? ADDR_IRQ_EN_LO : ADDR_IRQ_EN_HI;
        logic lo_dead;
        logic hi_paired;
        logic ctrl_wr;
        logic fl_wr;

        assign lo_dead   = IS_LO && (ctrl_wr ? bus_in.wdata[CTRL_WIDTH_BIT] : width[P]);
        assign hi_paired = !IS_LO && width[P];
        assign ctrl_wr   = bus_in.wr && (bus_in.addr == ADDR_CTRL_BASE + 16'(i));
        assign fl_wr     = bus_in.wr && (bus_in.addr == FA);
        assign fall[i]   = tclk_q[i] && !tclk_in[i];
        assign rise[i]   = !tclk_q[i] && tclk_in[i];

        // Timer clock sample
        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                tclk_q[i] <= 1'b0;
            end else if (ce_in) begin
                tclk_q[i] <= tclk_in[i];
            end
        end

        // Control bits; paired mode pins the low enables and high run to 0
        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                run_req[i] <= 1'b0;
                out_en[i]  <= 1'b0;
                inv_en[i]  <= 1'b0;
            end else if (ce_in) begin
                if (ctrl_wr) begin
                    run_req[i] <= bus_in.wdata[CTRL_RUN_BIT] && !hi_paired;
                    out_en[i]  <= bus_in.wdata[CTRL_OUT_BIT] && !lo_dead;
                    inv_en[i]  <= bus_in.wdata[CTRL_INV_BIT] && !lo_dead;
                end else begin
                    if (lo_dead) begin
                        out_en[i] <= 1'b0;
                        inv_en[i] <= 1'b0;
                    end
                    if (hi_paired) run_req[i] <= 1'b0;
                end
            end
        end

        // Reload and compare data
        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                reload[i] <= RESET_RELOAD;
                cmp[i]    <= RESET_CMP;
            end else if (ce_in && bus_in.wr) begin
                if (bus_in.addr == ADDR_RELOAD_BASE + 16'(i)) reload[i] <= bus_in.wdata;
                if (bus_in.addr == ADDR_CMP_BASE + 16'(i)) cmp[i] <= bus_in.wdata;
            end
        end

        // Interrupt enables
        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                uf_en[i] <= 1'b0;
                cm_en[i] <= 1'b0;
            end else if (ce_in && bus_in.wr && bus_in.addr == EA) begin
                uf_en[i] <= bus_in.wdata[B];
                cm_en[i] <= bus_in.wdata[B + 1];
            end
        end

        // Event flags: set beats a same-cycle clear
        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                uf_flag[i] <= 1'b0;
                cm_flag[i] <= 1'b0;
            end else if (ce_in) begin
                uf_flag[i] <= (uf_flag[i] && !(fl_wr && bus_in.wdata[B])) || uf_ev[i];
                cm_flag[i] <= (cm_flag[i] && !(fl_wr && bus_in.wdata[B + 1]))
                              || cm_ev[i];
            end
        end

        // Enabled pending event; low channel inert when paired
        assign cond[i] = !lo_dead &&
                         ((uf_flag[i] && uf_en[i]) || (cm_flag[i] && cm_en[i]));
    end

    // Per-pair counting, reload and output clock
    for (genvar p = 0; p < NPAIR; p++) begin : g_pair
        localparam int LO = 2 * p;
        localparam int HI = 2 * p + 1;
        logic       m16;
        logic       step_lo;
        logic       step_hi;
        logic       lo_zero;
        logic       hi_zero;
        logic [7:0] dec_lo;
        logic [7:0] dec_hi;
        logic [7:0] new_hi;

        // Step and event decode
        always_comb begin
            m16     = width[p];
            lo_zero = cnt[LO] == 8'h00;
            hi_zero = cnt[HI] == 8'h00;
            dec_lo  = cnt[LO] - 8'h01;
            dec_hi  = cnt[HI] - 8'h01;
            new_hi  = lo_zero ? dec_hi : cnt[HI];
            step_lo = fall[LO] && run_st[LO] == RUN_COUNTING && !sleep_in;
            step_hi = m16 ? (step_lo && lo_zero)
                          : (fall[HI] && run_st[HI] == RUN_COUNTING && !sleep_in);
            uf_ev[LO] = !m16 && step_lo && lo_zero;
            cm_ev[LO] = !m16 && step_lo && dec_lo == cmp[LO];
            uf_ev[HI] = step_hi && hi_zero;
            cm_ev[HI] = m16 ? (step_lo && {new_hi, dec_lo} == {cmp[HI], cmp[LO]})
                            : (step_hi && dec_hi == cmp[HI]);
        end

        // Run state follows the request only at a falling timer edge
        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                run_st[LO] <= RUN_STOPPED;
                run_st[HI] <= RUN_STOPPED;
            end else if (ce_in) begin
                run_st[LO] <= next_run(run_st[LO], fall[LO], run_req[LO]);
                run_st[HI] <= next_run(run_st[HI], fall[HI], run_req[HI]);
            end
        end

        // Width select lives in the low channel control register
        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                width[p] <= 1'b0;
            end else if (ce_in && bus_in.wr && bus_in.addr == ADDR_CTRL_BASE + 16'(LO)) begin
                width[p] <= bus_in.wdata[CTRL_WIDTH_BIT];
            end
        end

        // Down count; low underflow borrows from high when paired
        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                cnt[LO]     <= RESET_CNT;
                cnt[HI]     <= RESET_CNT;
                rl_pend[LO] <= 1'b0;
                rl_pend[HI] <= 1'b0;
            end else if (ce_in) begin
                if (step_lo) cnt[LO] <= dec_lo;
                if (step_hi) cnt[HI] <= dec_hi;
                if (rl_pend[LO] && rise[LO]) begin
                    cnt[LO]     <= reload[LO];
                    rl_pend[LO] <= 1'b0;
                    if (m16) cnt[HI] <= reload[HI];
                end else if (m16 ? uf_ev[HI] : uf_ev[LO]) begin
                    rl_pend[LO] <= 1'b1;
                end
                if (m16) begin
                    rl_pend[HI] <= 1'b0;
                end else if (rl_pend[HI] && rise[HI]) begin
                    cnt[HI]     <= reload[HI];
                    rl_pend[HI] <= 1'b0;
                end else if (uf_ev[HI]) begin
                    rl_pend[HI] <= 1'b1;
                end
            end
        end

        // Output clock: high from match, low from underflow
        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                timer_out_clock[LO] <= 1'b0;
                timer_out_clock[HI] <= 1'b0;
            end else if (ce_in) begin
                if (cm_ev[LO]) timer_out_clock[LO] <= 1'b1;
                else if (uf_ev[LO]) timer_out_clock[LO] <= 1'b0;
                if (cm_ev[HI]) timer_out_clock[HI] <= 1'b1;
                else if (uf_ev[HI]) timer_out_clock[HI] <= 1'b0;
            end
        end
    end

    // Priority and pin registers
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int k = 0; k < NPAIR; k++) prio[k] <= PRIO_NONE;
            pin_reg <= RESET_REG;
        end else if (ce_in && bus_in.wr) begin
            if (bus_in.addr == ADDR_PRIO) begin
                for (int k = 0; k < NPAIR; k++) prio[k] <= ptc_prio_t'(bus_in.wdata[2 * k +: 2]);
            end
            if (bus_in.addr == ADDR_PIN) pin_reg <= bus_in.wdata;
        end
    end

    // Interrupt request per pair, gated by mask level
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_req_out <= 4'h0;
        end else if (ce_in) begin
            for (int k = 0; k < NPAIR; k++) begin
                irq_req_out[k] <= (cond[2 * k] || cond[2 * k + 1])
                                  && (prio[k] > cpu_mask_level_in);
            end
        end
    end

    // Pin drive; routed clock overrides direction and data bits
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_a_out <= '{level: 1'b0, oe_n: 1'b1};
            pin_b_out <= '{level: 1'b0, oe_n: 1'b1};
            pin_c_out <= '{level: 1'b0, oe_n: 1'b1};
        end else if (ce_in) begin
            pin_a_out <= pick_pin(out_en[1], timer_out_clock[1],
                                  out_en[0] && !width[0], timer_out_clock[0],
                                  pin_reg[PIN_DIR_A_BIT], pin_reg[PIN_DATA_A_BIT]);
            pin_b_out <= pick_pin(out_en[3], timer_out_clock[3],
                                  out_en[2] && !width[1], timer_out_clock[2],
                                  pin_reg[PIN_DIR_B_BIT], pin_reg[PIN_DATA_B_BIT]);
            pin_c_out <= pick_pin(inv_en[3], !timer_out_clock[3],
                                  inv_en[2] && !width[1], !timer_out_clock[2],
                                  pin_reg[PIN_DIR_C_BIT], pin_reg[PIN_DATA_C_BIT]);
        end
    end

    // Read data assembly
    always_comb begin
        for (int g = 0; g < 2; g++) begin
            rd_en[g] = 8'h00;
            rd_fl[g] = 8'h00;
            for (int j = 0; j < 4; j++) begin
                rd_en[g][2 * j]     = uf_en[4 * g + j];
                rd_en[g][2 * j + 1] = cm_en[4 * g + j];
                rd_fl[g][2 * j]     = uf_flag[4 * g + j];
                rd_fl[g][2 * j + 1] = cm_flag[4 * g + j];
            end
        end
        next_rdata = 8'h00;
        case (bus_in.addr)
            ADDR_IRQ_EN_LO:   next_rdata = rd_en[0];
            ADDR_IRQ_EN_HI:   next_rdata = rd_en[1];
            ADDR_IRQ_FLAG_LO: next_rdata = rd_fl[0];
            ADDR_IRQ_FLAG_HI: next_rdata = rd_fl[1];
            ADDR_PRIO:        next_rdata = {prio[3], prio[2], prio[1], prio[0]};
            ADDR_PIN:         next_rdata = pin_reg;
            default:          next_rdata = 8'h00;
        endcase
        for (int k = 0; k < NCH; k++) begin
            if (bus_in.addr == ADDR_CTRL_BASE + 16'(k)) begin
                next_rdata = {width[k / 2] && (k % 2 == 0), 4'h0, inv_en[k], out_en[k],
                              run_req[k] || run_st[k] == RUN_COUNTING};
            end
            if (bus_in.addr == ADDR_RELOAD_BASE + 16'(k)) next_rdata = reload[k];
            if (bus_in.addr == ADDR_CMP_BASE + 16'(k)) next_rdata = cmp[k];
            if (bus_in.addr == ADDR_CNT_BASE + 16'(k)) next_rdata = cnt[k];
        end
    end

    // Read data stands one cycle after the strobe only
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= 8'h00;
        end else if (ce_in) begin
            rdata_out <= bus_in.rd ? next_rdata : 8'h00;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_uf_lo;
        ce_in && uf_ev[0];
    endsequence
    sequence s_pend_rise;
        ce_in && rl_pend[0] && rise[0] && !width[0];
    endsequence

    a_stop_extra_step: assert property (
        ce_in && fall[0] && run_st[0] == RUN_COUNTING && !run_req[0] && !sleep_in && !width[0]
        |=> run_st[0] == RUN_STOPPED && cnt[0] == $past(cnt[0]) - 8'h01)
        else $error("stop did not count one more step");
    a_reload_arm: assert property (s_uf_lo |=> rl_pend[0])
        else $error("underflow did not arm reload");
    a_reload_load: assert property (s_pend_rise |=> cnt[0] == $past(reload[0]) && !rl_pend[0])
        else $error("reload not taken at rising edge");
    a_flag_set_wins: assert property (ce_in && uf_ev[1] |=> uf_flag[1])
        else $error("underflow flag not set");
    a_flag_clear: assert property (
        ce_in && bus_in.wr && bus_in.addr == ADDR_IRQ_FLAG_LO && bus_in.wdata[1] && !cm_ev[0]
        |=> !cm_flag[0])
        else $error("write one did not clear flag");
    a_low_silent: assert property (width[0] |-> !uf_ev[0] && !cm_ev[0])
        else $error("paired low channel raised an event");
    a_low_en_held: assert property (width[1] |-> !out_en[2] && !inv_en[2])
        else $error("paired low enable not held at zero");
    a_odd_wins: assert property (
        ce_in && out_en[1] && out_en[0] |=> pin_a_out.level == $past(timer_out_clock[1]) && !pin_a_out.oe_n)
        else $error("odd timer did not win pin a");
    a_pin_override: assert property (
        ce_in && out_en[3] && !pin_reg[PIN_DIR_B_BIT] |=> !pin_b_out.oe_n)
        else $error("routed pin b not driven");
    a_inv_pin: assert property (ce_in && inv_en[3] |=> pin_c_out.level == !$past(timer_out_clock[3]))
        else $error("pin c not complement of timer 3");
    a_irq_gate: assert property (
        ce_in && prio[0] <= cpu_mask_level_in |=> !irq_req_out[0])
        else $error("request raised at or below mask level");
endmodule : ptc_timer_ctrl

/* testbench/ptc_port_model.sv */
// Far-side model: port pin wires and CPU mask level
`timescale 1ns/1ps
module ptc_port_model (
    input  logic              clk_in,
    input  logic              rstn_in,
    input  ptc_pkg::ptc_pin_t pin_a_in,
    input  ptc_pkg::ptc_pin_t pin_b_in,
    input  ptc_pkg::ptc_pin_t pin_c_in,
    input  logic [1:0]        mask_set_in,
    output logic [1:0]        mask_out,
    output logic [2:0]        wire_out
);
    import ptc_pkg::*;
    logic [2:0] lv;
    logic [2:0] oen;
    logic [2:0] last;
    assign lv  = {pin_c_in.level, pin_b_in.level, pin_a_in.level};
    assign oen = {pin_c_in.oe_n, pin_b_in.oe_n, pin_a_in.oe_n};
    // Released pin has no pull: show the inverse of its last driven level
    assign wire_out = (lv & ~oen) | (~last & oen);
    // Remember driven levels; CPU mask level follows the bench a cycle later
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            last     <= 3'h0;
            mask_out <= 2'h0;
        end else begin
            last     <= (lv & ~oen) | (last & oen);
            mask_out <= mask_set_in;
        end
    end
endmodule : ptc_port_model

/* testbench/tb_ptc_timer_ctrl.sv */
// Self-checking bench for timer pin routing and interrupt flags
`timescale 1ns/1ps
module tb_ptc_timer_ctrl;
    import ptc_pkg::*;
    logic         clk_in;
    logic         rstn_in;
    ptc_bus_req_t bus;
    logic [7:0]   rdata;
    logic [7:0]   tclk;
    logic [1:0]   mask_set;
    logic [1:0]   mask;
    ptc_pin_t     pin_a;
    ptc_pin_t     pin_b;
    ptc_pin_t     pin_c;
    logic [3:0]   irq;
    logic         ce;
    logic         sleep;
    logic [2:0]   pw;
    int           n_fail;
    int           n_compared;
    int           p;
    ptc_timer_ctrl ptc_timer_ctrl_i (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
        .bus_in(bus), .rdata_out(rdata), .tclk_in(tclk), .sleep_in(sleep),
        .cpu_mask_level_in(mask), .pin_a_out(pin_a), .pin_b_out(pin_b),
        .pin_c_out(pin_c), .irq_req_out(irq));
    ptc_port_model ptc_port_model_i (.clk_in(clk_in), .rstn_in(rstn_in), .pin_a_in(pin_a),
        .pin_b_in(pin_b), .pin_c_in(pin_c), .mask_set_in(mask_set), .mask_out(mask),
        .wire_out(pw));
    // Compare and count
    task automatic chk(input string s, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", s, exp, got);
        end
    endtask : chk
    // One-cycle write strobe
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus <= '0;
    endtask : wr
    // One-cycle read strobe, data checked in the following cycle
    task automatic rd(input logic [15:0] a, input logic [7:0] e, input string s);
        @(posedge clk_in);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus <= '0;
        #1 chk(s, rdata, e);
    endtask : rd
    // Falling edges on every timer input clock
    task automatic falls(input int n);
        repeat (n) begin
            @(posedge clk_in);
            tclk <= 8'h00;
            repeat (2) @(posedge clk_in);
            tclk <= 8'hff;
            repeat (2) @(posedge clk_in);
        end
    endtask : falls
    task automatic settle;
        repeat (4) @(posedge clk_in);
        #1;
    endtask : settle
    task automatic summarize;
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    // 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Hang guard
    initial begin
        #500us;
        n_fail++;
        summarize;
    end
    // Main sequence
    initial begin
        rstn_in = 1'b0;
        bus = '0;
        tclk = 8'hff;
        mask_set = 2'h0;
        ce = 1'b1;
        sleep = 1'b0;
        n_fail = 0;
        n_compared = 0;
        repeat (10) @(posedge clk_in);
        rstn_in <= 1'b1;
        rd(ADDR_IRQ_EN_LO, 8'h00, "en_lo");
        rd(ADDR_IRQ_FLAG_LO, 8'h00, "flag_lo");
        rd(ADDR_IRQ_FLAG_HI, 8'h00, "flag_hi");
        rd(ADDR_PRIO, 8'h00, "prio");
        rd(16'h0000, 8'h00, "unmapped");
        chk("pin_a oe_n", {7'h0, pin_a.oe_n}, 8'h01);
        wr(16'h0000, 8'hff);
        wr(ADDR_IRQ_EN_HI, 8'ha5);
        rd(ADDR_IRQ_EN_HI, 8'ha5, "en_hi");
        // Write strobe lost while the clock enable is low
        ce <= 1'b0;
        wr(ADDR_IRQ_EN_HI, 8'h00);
        ce <= 1'b1;
        rd(ADDR_IRQ_EN_HI, 8'ha5, "ce freeze");
        $display("test reset done");
        wr(ADDR_CTRL_BASE + 16'h2, 8'h86);
        rd(ADDR_CTRL_BASE + 16'h2, 8'h80, "paired low ctrl");
        settle;
        chk("pin_b oe_n", {7'h0, pin_b.oe_n}, 8'h01);
        chk("pin_c oe_n", {7'h0, pin_c.oe_n}, 8'h01);
        wr(ADDR_CTRL_BASE + 16'h2, 8'h06);
        settle;
        chk("pin_c drive", {7'h0, pin_c.oe_n}, 8'h00);
        chk("pin_c inverse", {7'h0, pw[2]}, {7'h0, ~pw[1]});
        wr(ADDR_CTRL_BASE + 16'h3, 8'h06);
        settle;
        chk("pin_c drive t3", {7'h0, pin_c.oe_n}, 8'h00);
        chk("pin_c inverse t3", {7'h0, pw[2]}, {7'h0, ~pw[1]});
        wr(ADDR_CTRL_BASE + 16'h2, 8'h00);
        wr(ADDR_CTRL_BASE + 16'h3, 8'h00);
        $display("test routing done");
        wr(ADDR_RELOAD_BASE + 16'h1, 8'hff);
        wr(ADDR_CMP_BASE + 16'h1, 8'h80);
        wr(ADDR_CTRL_BASE, 8'h01);
        wr(ADDR_CTRL_BASE + 16'h1, 8'h01);
        falls(130);
        rd(ADDR_IRQ_FLAG_LO, 8'h08, "match t1");
        wr(ADDR_CTRL_BASE, 8'h03);
        wr(ADDR_CTRL_BASE + 16'h1, 8'h03);
        settle;
        chk("odd wins", {7'h0, pw[0]}, 8'h01);
        wr(ADDR_PIN, 8'h11);
        wr(ADDR_CTRL_BASE + 16'h1, 8'h01);
        settle;
        chk("pin_a t0", {7'h0, pw[0]}, 8'h00);
        falls(140);
        rd(ADDR_IRQ_FLAG_LO, 8'h0f, "uf flags");
        wr(ADDR_IRQ_EN_LO, 8'h01);
        mask_set <= 2'h1;
        // Every priority code against mask level 1
        for (p = 0; p < 4; p++) begin
            wr(ADDR_PRIO, 8'(p));
            settle;
            chk("irq prio", {7'h0, irq[0]}, {7'h0, p > 1});
        end
        mask_set <= 2'h3;
        settle;
        chk("irq masked", {7'h0, irq[0]}, 8'h00);
        mask_set <= 2'h0;
        wr(ADDR_IRQ_EN_LO, 8'h00);
        settle;
        chk("irq off", {7'h0, irq[0]}, 8'h00);
        wr(ADDR_IRQ_FLAG_LO, 8'h00);
        rd(ADDR_IRQ_FLAG_LO, 8'h0f, "w0 flags");
        wr(ADDR_IRQ_FLAG_LO, 8'h05);
        rd(ADDR_IRQ_FLAG_LO, 8'h0a, "w1 flags");
        wr(ADDR_IRQ_FLAG_LO, 8'h0a);
        rd(ADDR_IRQ_FLAG_LO, 8'h00, "w1 match flags");
        $display("test counting done");
        // Stop timer 0 with output off; timer 1 runs on, output off, to probe sleep
        wr(ADDR_CTRL_BASE, 8'h00);
        rd(ADDR_CTRL_BASE, 8'h01, "run until stop");
        falls(1);
        rd(ADDR_CNT_BASE, 8'hf1, "stop extra step");
        rd(ADDR_CTRL_BASE, 8'h00, "stopped");
        sleep <= 1'b1;
        falls(3);
        sleep <= 1'b0;
        rd(ADDR_CNT_BASE + 16'h1, 8'hf1, "sleep hold");
        $display("test sleep done");
        summarize;
    end
endmodule : tb_ptc_timer_ctrl
